// *** hdl/ssr_defs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH
`define SSR_CTRL 8'h00
`define SSR_TGT 8'h04
`define SSR_STF 8'h08
`define SSR_SDC 8'h0C
`define SSR_BFQ 8'h10
`define SSR_BTM 8'h14
`define SSR_BCU 8'h18
`define SSR_SCR 8'h1C
`define SSR_ACC0 8'h20
`define SSR_LIM 8'h30
`define SSR_RAT 8'h34
`define SSR_STAT 8'h38
`define SSR_ELAP 8'h3C
`define SSR_C_RUN 0
`define SSR_C_DIR 1
`define SSR_C_PRE 2
`define SSR_C_COAST 3
`define SSR_C_RAMP 5:4
`define SSR_C_SEL 7:6
`define SSR_STF_RST 32'h0000_0032
`define SSR_BCU_RST 32'h0320_001E
`define SSR_SCR_RST 32'h012C_012C
`define SSR_ACC_RST 32'h0064_0064
`define SSR_LIM_RST 32'h1388_1388
`define SSR_RAT_RST 32'h0064_0064
`define SSR_CLK_NS 5
`define SSR_TICK_NS 1000000
`define SSR_TENTH_TICKS 100
`define SSR_PCT_FULL 100
`define SSR_PERMIL_FULL 1000
`endif

// *** hdl/ssr_pkg.sv ***
// types shared by the start/stop sequencer
package ssr_pkg;
   typedef enum logic [2:0] {
      ssr_idle = 3'b000, ssr_stby = 3'b001, ssr_pre = 3'b010, ssr_hold = 3'b011,
      ssr_run = 3'b100, ssr_dec = 3'b101, ssr_wait = 3'b110, ssr_brk = 3'b111
   } ssr_state_t;
   typedef enum logic [1:0] {ssr_lin = 2'b00, ssr_sa = 2'b01, ssr_sb = 2'b10} ssr_ramp_t;
endpackage

// *** hdl/ssr_seq.sv ***
// start/stop sequencer and output frequency ramp with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
// Summary of operation
// - run: output startup frequency, hold it, then ramp to target
// - startup frequency ignores lower limit; target below it means standby
// - direction reversal skips the startup hold
// - hold not in ramp time but counted in program stage elapsed time
// - direct start: startup dc braking at set current for set time
// - startup braking time zero skips startup braking
// - pre-excitation start: magnetise at set current for set time
// - pre-excitation time zero starts directly
// - startup current is percent of inverter rated current
// - stop mode 0 decelerates to zero, 1 coasts
// - coast stop cuts output at once
// - stop braking starts when frequency falls to brake start frequency
// - output suppressed for wait time before stop braking
// - stop braking current is percent of motor rated, default 30
// - stop braking held for its time; zero cancels it
// - brake usage ratio only on units with braking unit, default 80
// - ramp select 0 linear, 1 s-curve a, 2 s-curve b, start and stop
// - linear ramp offers four selectable time sets
// - s-curve b inflection at motor rated frequency
// - s-curve b above rated takes T times (4/9 ratio squared + 5/9)
// - s-curve a ratios default 30, sum capped at 100 percent
// - s-curve a slope rises in start, constant, falls to zero at end
module ssr_seq #(
   parameter int unsigned TICK_CYC = `SSR_TICK_NS / `SSR_CLK_NS,
   parameter bit HAS_BRAKE_UNIT = 1'b1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // power stage drive
   output logic out_en,
   output logic out_dir,
   output logic [15:0] out_freq,
   output logic dc_en,
   output logic mag_en,
   output logic [15:0] dc_cur,
   output logic [9:0] brake_use
);
   // scaled product a*b/c, saturating, zero divisor gives full scale
   function automatic logic [31:0] mdiv(input logic [31:0] a, input logic [31:0] b,
                                        input logic [31:0] c);
      logic [63:0] q;
      q = (c == 32'h0) ? 64'hFFFF_FFFF : (64'(a) * 64'(b)) / 64'(c);
      mdiv = (q > 64'hFFFF_FFFF) ? 32'hFFFF_FFFF : q[31:0];
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = o;
      for (int i = 0; i < 4; i++)
         if (s[i])
            merge[8*i +: 8] = d[8*i +: 8];
   endfunction

   // reset value of each configuration word
   function automatic logic [31:0] rst_val(input int i);
      case (8'(i * 4))
         `SSR_STF: rst_val = `SSR_STF_RST;
         `SSR_BCU: rst_val = `SSR_BCU_RST;
         `SSR_SCR: rst_val = `SSR_SCR_RST;
         `SSR_LIM: rst_val = `SSR_LIM_RST;
         `SSR_RAT: rst_val = `SSR_RAT_RST;
         default: rst_val = (i >= 8 && i < 12) ? `SSR_ACC_RST : 32'h0;
      endcase
   endfunction

   localparam int NCFG = `SSR_STAT / 4;
   logic [31:0] cfg_r [0:NCFG-1];
   logic aw_rdy_r, w_rdy_r, b_vld_r, ar_rdy_r, r_vld_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r, r_data_r;
   logic [3:0] w_strb_r;
   logic [1:0] b_resp_r, r_resp_r;
   ssr_pkg::ssr_state_t st_r, st_nxt;
   logic [31:0] f_r, f_nxt, tick_r, rc_r;
   logic [6:0] tenth_r;
   logic [15:0] tmr_r, elap_r;
   logic dir_r;
   logic oen_r, dc_r, mag_r;
   logic [15:0] cur_r;
   logic [9:0] use_r;

   // write channel: address and data taken in either order, answer after both
   wire wr_go = !aw_rdy_r && !w_rdy_r && !b_vld_r;
   wire [3:0] wr_idx = aw_addr_r[5:2];
   wire wr_ok = (aw_addr_r[7:6] == 2'b00) && (aw_addr_r[1:0] == 2'b00);
   wire wr_cfg = wr_go && wr_ok && (32'(wr_idx) < NCFG);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         b_vld_r <= 1'b0;
         b_resp_r <= 2'b00;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && aw_rdy_r)
         begin
            aw_rdy_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && w_rdy_r)
         begin
            w_rdy_r <= 1'b0;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            b_vld_r <= 1'b1;
            b_resp_r <= wr_ok ? 2'b00 : 2'b10; // slverr outside the map
         end
         if (b_vld_r && s_axi_bready)
         begin
            b_vld_r <= 1'b0;
            aw_rdy_r <= 1'b1;
            w_rdy_r <= 1'b1;
         end
      end
   end

   // configuration words, read-only status above them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         for (int i = 0; i < NCFG; i++)
            cfg_r[i] <= rst_val(i);
      else if (wr_cfg)
         cfg_r[wr_idx] <= merge(cfg_r[wr_idx], w_data_r, w_strb_r);
   end

   // field decode
   wire run_cmd = cfg_r[`SSR_CTRL/4][`SSR_C_RUN];
   wire dir_cmd = cfg_r[`SSR_CTRL/4][`SSR_C_DIR];
   wire pre_mode = cfg_r[`SSR_CTRL/4][`SSR_C_PRE];
   wire coast = cfg_r[`SSR_CTRL/4][`SSR_C_COAST];
   wire [1:0] ramp = cfg_r[`SSR_CTRL/4][`SSR_C_RAMP];
   wire [1:0] tsel = cfg_r[`SSR_CTRL/4][`SSR_C_SEL];
   wire [15:0] tgt_f = cfg_r[`SSR_TGT/4][15:0];
   wire [15:0] stf_f = cfg_r[`SSR_STF/4][15:0];
   wire [15:0] hold_t = cfg_r[`SSR_STF/4][31:16];
   wire [7:0] sdc_pct = cfg_r[`SSR_SDC/4][7:0];
   wire [15:0] sdc_t = cfg_r[`SSR_SDC/4][31:16];
   wire [15:0] bfq_f = cfg_r[`SSR_BFQ/4][15:0];
   wire [15:0] bwait_t = cfg_r[`SSR_BTM/4][15:0];
   wire [15:0] brk_t = cfg_r[`SSR_BTM/4][31:16];
   wire [7:0] bcu_pct = cfg_r[`SSR_BCU/4][7:0];
   wire [15:0] maxf = cfg_r[`SSR_LIM/4][15:0];
   wire [15:0] ratf = cfg_r[`SSR_LIM/4][31:16];
   wire [15:0] inv_rat = cfg_r[`SSR_RAT/4][15:0];
   wire [15:0] mot_rat = cfg_r[`SSR_RAT/4][31:16];
   wire [31:0] acc_w = cfg_r[`SSR_ACC0/4 + 32'(tsel)];

   // s-curve a ratios, each capped so their sum stays within full scale
   wire [9:0] s1_raw = cfg_r[`SSR_SCR/4][9:0];
   wire [9:0] s2_raw = cfg_r[`SSR_SCR/4][25:16];
   wire [9:0] s1 = (s1_raw > 10'(`SSR_PERMIL_FULL)) ? 10'(`SSR_PERMIL_FULL) : s1_raw;
   wire [9:0] s2 = (s2_raw > 10'(`SSR_PERMIL_FULL) - s1) ? 10'(`SSR_PERMIL_FULL) - s1
                   : s2_raw;

   // control tick and tenth-second pulses
   wire tick = (tick_r == TICK_CYC - 1);
   wire tenth = tick && (tenth_r == 7'(`SSR_TENTH_TICKS - 1));

   // ramp target: zero while stopping or reversing
   wire rev = dir_cmd != dir_r;
   wire [15:0] tgt_eff = (st_r == ssr_pkg::ssr_run && !rev) ? tgt_f : 16'h0;
   wire [31:0] tgt_fx = {tgt_eff, 16'h0};
   wire up = f_r < tgt_fx;
   wire [31:0] tt = 32'(up ? acc_w[15:0] : acc_w[31:16]) * `SSR_TENTH_TICKS;
   wire [31:0] rc_c = (rc_r > tt) ? tt : rc_r;

   // linear step spans zero to maximum frequency in the ramp time
   wire [31:0] lin_s = mdiv({maxf, 16'h0}, 32'h1, tt);
   // s-curve a: peak slope keeps the linear ramp time
   wire [31:0] t1 = mdiv(tt, 32'(s1), `SSR_PERMIL_FULL);
   wire [31:0] t2 = mdiv(tt, 32'(s2), `SSR_PERMIL_FULL);
   wire [31:0] pk_s = mdiv(lin_s, 2 * `SSR_PERMIL_FULL, 32'(2 * `SSR_PERMIL_FULL) - s1 - s2);
   wire [31:0] rem = (tt > rc_c) ? tt - rc_c : 32'h1;
   wire [31:0] sa_s = (rc_r < t1) ? mdiv(pk_s, rc_r + 1, t1)
                    : (t2 != 0 && rc_r + t2 >= tt) ? mdiv(pk_s, rem, t2) : pk_s;
   // s-curve b: rising slope below rated when accelerating, constant when decelerating, slope k/f above it
   wire [31:0] fb_s = mdiv({ratf, 16'h0}, 32'h1, tt);
   wire above = f_r[31:16] >= ratf;
   wire [31:0] sb_hi = mdiv(fb_s, 9 * 32'(ratf), 8 * 32'(f_r[31:16]));
   wire [31:0] sb_lo = up ? mdiv(fb_s, 7 * tt + 2 * rc_c, 8 * tt) : fb_s;
   wire [31:0] sb_s = above ? sb_hi : sb_lo;
   wire [31:0] sel_s = (ramp == ssr_pkg::ssr_sa) ? sa_s
                     : (ramp == ssr_pkg::ssr_sb) ? sb_s : lin_s;
   wire [31:0] step = (sel_s == 32'h0) ? 32'h1 : sel_s;
   wire [32:0] f_up = 33'(f_r) + 33'(step);
   wire [31:0] f_ramp = up ? ((f_up > 33'(tgt_fx)) ? tgt_fx : f_up[31:0])
                      : ((f_r - tgt_fx > step) ? f_r - step : tgt_fx);

   // sequence control
   wire can_start = tgt_f >= stf_f;
   wire brk_now = (brk_t != 16'h0) && (f_r[31:16] <= bfq_f);
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         ssr_pkg::ssr_idle:
            if (run_cmd)
               st_nxt = can_start ? ssr_pkg::ssr_pre : ssr_pkg::ssr_stby;
         ssr_pkg::ssr_stby:
            if (!run_cmd)
               st_nxt = ssr_pkg::ssr_idle;
            else if (can_start)
               st_nxt = ssr_pkg::ssr_pre;
         ssr_pkg::ssr_pre, ssr_pkg::ssr_hold, ssr_pkg::ssr_run:
            if (!run_cmd)
               st_nxt = coast ? ssr_pkg::ssr_idle : ssr_pkg::ssr_dec;
            else if (st_r == ssr_pkg::ssr_pre && tmr_r >= sdc_t)
               st_nxt = ssr_pkg::ssr_hold;
            else if (st_r == ssr_pkg::ssr_hold && tmr_r >= hold_t)
               st_nxt = ssr_pkg::ssr_run;
         ssr_pkg::ssr_dec:
            if (run_cmd)
               st_nxt = ssr_pkg::ssr_run;
            else if (brk_now)
               st_nxt = ssr_pkg::ssr_wait;
            else if (f_r == 32'h0)
               st_nxt = ssr_pkg::ssr_idle;
         ssr_pkg::ssr_wait:
            if (tmr_r >= bwait_t)
               st_nxt = ssr_pkg::ssr_brk;
         ssr_pkg::ssr_brk:
            if (tmr_r >= brk_t)
               st_nxt = ssr_pkg::ssr_idle;
         default:
            st_nxt = ssr_pkg::ssr_idle;
      endcase
   end

   // output frequency per state
   always_comb
   begin
      f_nxt = f_r;
      case (st_nxt)
         ssr_pkg::ssr_hold:
            f_nxt = {stf_f, 16'h0};
         ssr_pkg::ssr_run, ssr_pkg::ssr_dec:
            if (tick)
               f_nxt = f_ramp;
         default:
            f_nxt = 32'h0;
      endcase
   end

   // state, frequency, tick and timers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= ssr_pkg::ssr_idle;
         f_r <= 32'h0;
         tick_r <= 32'h0;
         tenth_r <= 7'h00;
         tmr_r <= 16'h0000;
         rc_r <= 32'h0;
         elap_r <= 16'h0000;
         dir_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         f_r <= f_nxt;
         // dividers restart with each phase so a phase of n tenths lasts n tenths
         if (st_nxt != st_r)
         begin
            tick_r <= 32'h0;
            tenth_r <= 7'h00;
         end
         else
         begin
            tick_r <= tick ? 32'h0 : tick_r + 1;
            if (tick)
               tenth_r <= tenth ? 7'h00 : tenth_r + 7'h01;
         end
         if (st_nxt != st_r)
            tmr_r <= 16'h0000;
         else if (tenth && tmr_r != 16'hFFFF)
            tmr_r <= tmr_r + 16'h0001;
         // ramp clock restarts per ramp; hold time never enters it
         if (st_r != ssr_pkg::ssr_run && st_r != ssr_pkg::ssr_dec || f_r == tgt_fx)
            rc_r <= 32'h0;
         else if (tick)
            rc_r <= rc_r + 1;
         // program stage elapsed time includes the hold
         if (st_r == ssr_pkg::ssr_idle)
            elap_r <= 16'h0000;
         else if (tenth && (st_r == ssr_pkg::ssr_hold || st_r == ssr_pkg::ssr_run))
            elap_r <= elap_r + 16'h0001;
         // reversal passes zero and ramps on without a hold
         if (st_r == ssr_pkg::ssr_idle || st_r == ssr_pkg::ssr_stby
             || (st_r == ssr_pkg::ssr_run && rev && f_r == 32'h0))
            dir_r <= dir_cmd;
      end
   end

   // power stage drive, one cycle behind the state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oen_r <= 1'b0;
         dc_r <= 1'b0;
         mag_r <= 1'b0;
         cur_r <= 16'h0000;
         use_r <= 10'h000;
      end
      else
      begin
         // an aborted start passes dec at zero frequency without switching on
         oen_r <= st_r inside {ssr_pkg::ssr_hold, ssr_pkg::ssr_run}
                  || (st_r == ssr_pkg::ssr_dec && f_r != 32'h0);
         dc_r <= (st_r == ssr_pkg::ssr_pre && !pre_mode && sdc_t != 16'h0)
                 || st_r == ssr_pkg::ssr_brk;
         mag_r <= st_r == ssr_pkg::ssr_pre && pre_mode && sdc_t != 16'h0;
         if (st_r == ssr_pkg::ssr_pre)
            cur_r <= 16'(mdiv(32'(sdc_pct), 32'(inv_rat), `SSR_PCT_FULL));
         else if (st_r == ssr_pkg::ssr_brk)
            cur_r <= 16'(mdiv(32'(bcu_pct), 32'(mot_rat), `SSR_PCT_FULL));
         else
            cur_r <= 16'h0000;
         use_r <= HAS_BRAKE_UNIT ? cfg_r[`SSR_BCU/4][25:16] : 10'h000;
      end
   end

   // read channel, answer one cycle after the address
   wire [7:0] ra = s_axi_araddr;
   wire r_ok = (ra[7:6] == 2'b00) && (ra[1:0] == 2'b00);
   wire [31:0] stat_w = {f_r[31:16], 11'h000, oen_r, dir_r, st_r};
   wire [31:0] rd_w = !r_ok ? 32'h0 : (ra == `SSR_STAT) ? stat_w
                    : (ra == `SSR_ELAP) ? {16'h0000, elap_r} : cfg_r[ra[5:2]];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_rdy_r <= 1'b1;
         r_vld_r <= 1'b0;
         r_data_r <= 32'h0;
         r_resp_r <= 2'b00;
      end
      else if (s_axi_arvalid && ar_rdy_r)
      begin
         ar_rdy_r <= 1'b0;
         r_vld_r <= 1'b1;
         r_data_r <= rd_w;
         r_resp_r <= r_ok ? 2'b00 : 2'b10;
      end
      else if (r_vld_r && s_axi_rready)
      begin
         r_vld_r <= 1'b0;
         ar_rdy_r <= 1'b1;
      end
   end

   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = w_rdy_r;
   assign s_axi_bvalid = b_vld_r;
   assign s_axi_bresp = b_resp_r;
   assign s_axi_arready = ar_rdy_r;
   assign s_axi_rvalid = r_vld_r;
   assign s_axi_rdata = r_data_r;
   assign s_axi_rresp = r_resp_r;
   assign out_en = oen_r;
   assign out_dir = dir_r;
   assign out_freq = f_r[31:16];
   assign dc_en = dc_r;
   assign mag_en = mag_r;
   assign dc_cur = cur_r;
   assign brake_use = use_r;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_stop_req;
      st_r inside {ssr_pkg::ssr_pre, ssr_pkg::ssr_hold, ssr_pkg::ssr_run} && !run_cmd;
   endsequence
   property p_standby;
      st_r == ssr_pkg::ssr_idle && run_cmd && tgt_f < stf_f |=> st_r == ssr_pkg::ssr_stby;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not entered");
   property p_hold_freq;
      st_r == ssr_pkg::ssr_hold |-> f_r[31:16] == stf_f ##1 out_en;
   endproperty
   a_hold_freq: assert property (p_hold_freq) else $error("hold frequency wrong");
   property p_coast;
      s_stop_req and coast |=> st_r == ssr_pkg::ssr_idle ##1 !out_en;
   endproperty
   a_coast: assert property (p_coast) else $error("coast did not cut output");
   property p_dec;
      s_stop_req and !coast |=> st_r == ssr_pkg::ssr_dec;
   endproperty
   a_dec: assert property (p_dec) else $error("stop sequence not entered");
   property p_wait;
      st_r == ssr_pkg::ssr_wait |=> !out_en && !dc_en;
   endproperty
   a_wait: assert property (p_wait) else $error("output during brake wait");
   property p_nobrk;
      st_r == ssr_pkg::ssr_dec && brk_t == 16'h0 |=> st_r != ssr_pkg::ssr_wait;
   endproperty
   a_nobrk: assert property (p_nobrk) else $error("zero brake time braked");
   property p_skip_pre;
      st_r == ssr_pkg::ssr_pre && run_cmd && sdc_t == 16'h0 |=> st_r == ssr_pkg::ssr_hold;
   endproperty
   a_skip_pre: assert property (p_skip_pre) else $error("zero time start phase");
   property p_zero_inj;
      st_r == ssr_pkg::ssr_pre && sdc_t == 16'h0 |=> !dc_en && !mag_en;
   endproperty
   a_zero_inj: assert property (p_zero_inj) else $error("zero time start injected");
   property p_rev;
      st_r == ssr_pkg::ssr_run && run_cmd && rev && f_r == 32'h0
      |=> st_r == ssr_pkg::ssr_run && dir_r == $past(dir_cmd);
   endproperty
   a_rev: assert property (p_rev) else $error("reversal entered hold");
   property p_cap;
      32'(s1) + 32'(s2) <= `SSR_PERMIL_FULL;
   endproperty
   a_cap: assert property (p_cap) else $error("s-curve ratios exceed full");
endmodule
`default_nettype wire

// *** verification/ssr_seq_tb_top.sv ***
// self-checking bench for the start/stop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_seq_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, out_en, out_dir, dc_en, mag_en;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, inj;
   wire [15:0] out_freq, dc_cur, spd;
   wire [9:0] brake_use;
   wire [5:0] fl = {out_freq == 16'h0032, out_dir, mag_en, dc_en, out_en, out_freq == 16'h0100};
   int error_cnt = 0;
   int cmp_count = 0;
   int n, i, j;
   logic [31:0] d, k;
   logic [1:0] r;
   // clock
   initial
   begin
      forever #2.5 aclk = ~aclk;
   end
   ssr_seq #(.TICK_CYC(20), .HAS_BRAKE_UNIT(1'b1)) i_ssr_seq (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .out_en(out_en), .out_dir(out_dir), .out_freq(out_freq), .dc_en(dc_en),
      .mag_en(mag_en), .dc_cur(dc_cur), .brake_use(brake_use));
   ssr_stage_model i_ssr_stage_model (.aclk(aclk), .aresetn(aresetn), .out_en(out_en),
      .out_freq(out_freq), .dc_en(dc_en), .mag_en(mag_en), .spd(spd), .inj_cyc(inj));
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // axi4-lite write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int c;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (c = 0; c < 100; c++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      if (c == 100)
      begin
         error_cnt++;
         close_out();
      end
      else
         @(posedge aclk); // one edge between transfers
   endtask
   // axi4-lite read
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int c;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (c = 0; c < 100; c++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (c == 100)
      begin
         error_cnt++;
         close_out();
      end
      else
         @(posedge aclk); // one edge between transfers
   endtask
   // bounded wait for a drive flag to reach a level
   task automatic wt(input int f, input logic v, input int lim, output int c);
      for (c = 1; c <= lim; c++)
      begin
         @(posedge aclk);
         if (fl[f] === v)
            return;
      end
      error_cnt++;
      $display("[ERR] wait flag %0d expected %b seen %b", f, v, fl[f]);
      close_out();
   endtask
   task automatic stop();
      wr(`SSR_CTRL, 32'h0000_0000);
      wt(1, 1'b0, 3000, n);
      repeat (50) @(posedge aclk);
   endtask
   function automatic logic [31:0] win(input int c, input int lo, input int hi);
      return 32'(c >= lo && c <= hi);
   endfunction
   // hang guard
   initial
   begin
      repeat (95000) @(posedge aclk);
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SSR_STF, d, r);
      chk("stf", `SSR_STF_RST, d);
      rd(`SSR_BCU, d, r);
      chk("bcu", `SSR_BCU_RST, d);
      rd(`SSR_SCR, d, r);
      chk("scr", `SSR_SCR_RST, d);
      rd(8'h40, d, r);
      chk("unmapped", 32'h0000_0002, 32'(r));
      chk("brake_use", 32'h0000_0320, 32'(brake_use));
      $display("test registers done");
      wr(`SSR_TGT, 32'h0000_0100);
      for (i = 0; i < 4; i++)
         wr(8'h20 + 8'(4 * i), 32'h0001_0001);
      wr(`SSR_STF, 32'h0001_0032);
      wr(`SSR_CTRL, 32'h0000_0001);
      wt(1, 1'b1, 200, n);
      chk("start freq", 32'h0000_0032, 32'(out_freq));
      wt(5, 1'b0, 3000, n);
      chk("hold time", 32'h1, win(n, 1960, 2080));
      wt(0, 1'b1, 400, n);
      chk("accel excl hold", 32'h1, win(n, 1, 400));
      rd(`SSR_ELAP, d, r);
      chk("elapsed", 32'h1, 32'(d[15:0] != 16'h0000));
      wr(`SSR_CTRL, 32'h0000_0003);
      wt(4, 1'b1, 500, n);
      wt(0, 1'b1, 1500, n);
      chk("reverse", 32'h1, 32'(out_dir));
      $display("test run and reverse done");
      wr(`SSR_BFQ, 32'h0000_0080);
      wr(`SSR_BTM, 32'h0001_0001);
      wr(`SSR_CTRL, 32'h0000_0002);
      wt(1, 1'b0, 2000, n);
      chk("brake freq", 32'h1, 32'(spd <= 16'h0080 && spd > 16'h0040));
      wt(2, 1'b1, 3000, n);
      chk("brake wait", 32'h1, win(n, 1960, 2080));
      chk("brake cur", 32'h0000_001E, 32'(dc_cur));
      wt(2, 1'b0, 3000, n);
      chk("brake time", 32'h1, win(n, 1960, 2080));
      repeat (50) @(posedge aclk);
      wr(`SSR_BTM, 32'h0000_0000);
      wr(`SSR_CTRL, 32'h0000_0009);
      wt(0, 1'b1, 3000, n);
      wr(`SSR_CTRL, 32'h0000_0008);
      wt(1, 1'b0, 4, n);
      chk("coast", 32'h1, 32'(spd > 16'h0080));
      repeat (50) @(posedge aclk);
      $display("test stop modes done");
      wr(`SSR_TGT, 32'h0000_0020);
      wr(`SSR_CTRL, 32'h0000_0001);
      repeat (100) @(posedge aclk);
      rd(`SSR_STAT, d, r);
      chk("standby", 32'h0000_0001, {29'h0, d[2:0]});
      chk("standby out", 32'h0, 32'(out_en));
      stop();
      wr(`SSR_TGT, 32'h0000_0100);
      wr(`SSR_STF, 32'h0000_0032);
      wr(`SSR_SDC, 32'h0001_0032);
      for (i = 0; i < 2; i++)
      begin
         wr(`SSR_CTRL, 32'(1 + 4 * i));
         wt(2 + i, 1'b1, 100, n);
         chk("start cur", 32'h0000_0032, 32'(dc_cur));
         wt(2 + i, 1'b0, 3000, n);
         chk("start phase", 32'h1, win(n, 1960, 2080));
         wt(1, 1'b1, 100, n);
         stop();
      end
      wr(`SSR_SDC, 32'h0000_0032);
      for (i = 0; i < 2; i++)
      begin
         k = inj;
         wr(`SSR_CTRL, 32'(1 + 4 * i));
         wt(1, 1'b1, 200, n);
         stop();
         chk("zero time", 32'h1, 32'(inj == k));
      end
      wr(`SSR_SDC, 32'h0001_0032);
      wr(`SSR_CTRL, 32'h0000_0001);
      wt(2, 1'b1, 100, n);
      repeat (300) @(posedge aclk);
      wr(`SSR_CTRL, 32'h0000_0000);
      wt(2, 1'b0, 100, n);
      chk("abort", 32'h0, 32'(out_en));
      repeat (50) @(posedge aclk);
      wr(`SSR_SDC, 32'h0000_0000);
      $display("test startup phases done");
      for (i = 0; i < 3; i++)
         for (j = 0; j < 4; j++)
         begin
            wr(`SSR_CTRL, 32'(j * 64 + i * 16 + 1));
            wt(0, 1'b1, 3000, n);
            chk("ramp", 32'h0000_0100, 32'(out_freq));
            stop();
         end
      $display("test ramp modes done");
      close_out();
   end
endmodule
`default_nettype wire

// *** verification/ssr_stage_model.sv ***
// behavioural power stage and motor load seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module ssr_stage_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // drive from the sequencer
   input wire logic out_en,
   input wire logic [15:0] out_freq,
   input wire logic dc_en,
   input wire logic mag_en,
   // observations for the bench
   output logic [15:0] spd,
   output logic [31:0] inj_cyc
);
   // motor follows the drive, coasts when released, stops under dc injection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         spd <= 16'h0000;
         inj_cyc <= 32'h0000_0000;
      end
      else
      begin
         // frequency drops a cycle before the enable, keep the last driven speed
         if (out_en)
         begin
            if (out_freq != 16'h0000)
               spd <= out_freq;
         end
         else if (dc_en)
            spd <= 16'h0000;
         else if (spd != 16'h0000)
            spd <= spd - 16'h0001;
         if (dc_en || mag_en)
            inj_cyc <= inj_cyc + 32'h0000_0001; // cycles of current injection
      end
   end
endmodule
`default_nettype wire
